/* bfs_pkg.sv */
// bfs_pkg: constants, comparator flag layout, states and drive bundle
// for the buck fault and bias sequencer.
// assumes a 50 MHz controller clock and digitized comparator flags.
package bfs_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned OV_FILTER_NS = 5000;
	// least time, so round up to whole cycles
	localparam int unsigned OV_FILTER_CYC = (OV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned UV_CONSEC_CYC = 8;
	localparam int unsigned SWOVER_SW_CYC = 32;
	// soft-start counter length has no printed figure; plain default
	localparam int unsigned SS_COUNT_CYC = 1024;
	localparam int unsigned CNT_W = 16;

	// ----------------------------------------------------------------
	// comparator flags, all asynchronous to i_clk
	// ----------------------------------------------------------------
	typedef struct packed {
		logic bias_above_on;      // bias_supply above 3 V
		logic bias_above_off;     // bias_supply above 2.4 V
		logic enable_powersave_in;             // enable_powersave_in enabled
		logic ldo_en_above_1v;    // ldo_enable_in above 1 V
		logic ldo_en_above_lock;  // ldo_enable_in above input lockout (2.6 V)
		logic fb_over;            // feedback_sense above 720 mV
		logic fb_pg_low;          // feedback_sense 10 % below nominal
		logic fb_pg_ok;           // feedback_sense above -8 % of nominal
		logic fb_under;           // feedback_sense below 450 mV
		logic ss_meets_fb;        // 40 % of soft-start ramp reached feedback
		logic il_negative;        // inductor current below zero
		logic ss_done;            // soft-start ramp complete
		logic on_time_req;        // loop asks for high-side on-time
		logic sw_cycle;           // one pulse per switching cycle
		logic bias_above_075;     // bias rail above 0.75 V
		logic bias_fb_above_90;   // bias_reg_feedback at 90 % of final
		logic bias_out_close;     // bias rail and output within 300 mV
	} bfs_cmp_t;

	localparam int unsigned CMP_W = $bits(bfs_cmp_t);

	// ----------------------------------------------------------------
	// sequencer states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_LOCKOUT = 7'h01,
		ST_POR = 7'h02,
		ST_IDLE = 7'h04,
		ST_PREBIAS = 7'h08,
		ST_RUN = 7'h10,
		ST_OV = 7'h20,
		ST_UV = 7'h40
	} bfs_state_t;

	// bias regulator current limit steps
	typedef enum logic [1:0] {
		ILIM_65MA = 2'h0,
		ILIM_115MA = 2'h1,
		ILIM_200MA = 2'h2
	} bfs_ilim_t;

	typedef struct packed {
		logic high_side;
		logic low_side;
	} bfs_drive_t;

	localparam bfs_drive_t DRIVE_OFF = '{high_side: 1'b0, low_side: 1'b0};

endpackage : bfs_pkg

/* bfs_plant.sv */
// bfs_plant: analog side of the sequencer, levels in mV to comparator flags.
// assumes the bench moves levels and loop flags on falling clock edges.
module bfs_plant (
	// clock
	input wire logic i_clk,
	// analog levels in mV
	input wire logic [15:0] i_fb_mv,
	input wire logic [15:0] i_bias_mv,
	input wire logic [15:0] i_ldo_mv,
	// loop flags and switching enable
	input wire logic i_sw_run,
	input wire bfs_pkg::bfs_cmp_t i_flags,
	// comparator flags to the block
	output bfs_pkg::bfs_cmp_t o_cmp
);
	// ----
	// comparators
	// ----
	logic [2:0] sw_q = 3'h0;
	logic run_q = 1'b0;

	// run request taken at the rising edge, so a falling-edge write never races
	always @(posedge i_clk) run_q <= i_sw_run;
	// switching cycle every eight clocks, none while stopped
	always @(negedge i_clk) sw_q <= run_q ? sw_q + 3'h1 : 3'h0;

	// thresholds around a 600 mV nominal feedback
	always_comb begin
		o_cmp = i_flags;
		o_cmp.bias_above_on = i_bias_mv > 16'd3000;
		o_cmp.bias_above_off = i_bias_mv > 16'd2400;
		o_cmp.ldo_en_above_1v = i_ldo_mv > 16'd1000;
		o_cmp.ldo_en_above_lock = i_ldo_mv > 16'd2600;
		o_cmp.fb_over = i_fb_mv > 16'd720;
		o_cmp.fb_pg_low = i_fb_mv < 16'd540; // gap to 552 gives hysteresis
		o_cmp.fb_pg_ok = i_fb_mv > 16'd552;
		o_cmp.fb_under = i_fb_mv < 16'd450;
		o_cmp.sw_cycle = sw_q[2];
	end
endmodule : bfs_plant

/* bfs_sequencer.sv */
// bfs_sequencer: supervisory and start-up sequencing of a buck switcher
// with an internal bias regulator.
// assumes every comparator flag is asynchronous and glitch-prone; gate
// drivers and the open-drain power-good pad sit outside.
module bfs_sequencer #(
	parameter int unsigned OV_FILTER_CYCLES = bfs_pkg::OV_FILTER_CYC,
	parameter int unsigned UV_CYCLES = bfs_pkg::UV_CONSEC_CYC,
	parameter int unsigned SWOVER_CYCLES = bfs_pkg::SWOVER_SW_CYC,
	parameter int unsigned SS_COUNT_CYCLES = bfs_pkg::SS_COUNT_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// comparator flags
	input wire bfs_pkg::bfs_cmp_t i_cmp,
	// gate drive
	output bfs_pkg::bfs_drive_t o_drive,
	// open-drain power good: oe high pulls the pad low
	output logic o_power_good,
	output logic o_power_good_oe,
	// bias regulator
	output logic o_ldo_on,
	output bfs_pkg::bfs_ilim_t o_ldo_ilim,
	output logic o_switchover,
	// status
	output logic o_por_clear,
	output logic o_ov_fault,
	output logic o_uv_fault
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	localparam int unsigned CNT_MAX = (1 << bfs_pkg::CNT_W) - 1;
	if (OV_FILTER_CYCLES < 1 || OV_FILTER_CYCLES > CNT_MAX ||
		UV_CYCLES < 1 || UV_CYCLES > CNT_MAX ||
		SWOVER_CYCLES < 1 || SWOVER_CYCLES > CNT_MAX ||
		SS_COUNT_CYCLES < 1 || SS_COUNT_CYCLES > CNT_MAX) begin : g_bad_param
		$error("bfs_sequencer: count parameter out of range");
	end

	localparam logic [bfs_pkg::CNT_W-1:0] OV_LAST = bfs_pkg::CNT_W'(OV_FILTER_CYCLES - 1);
	localparam logic [bfs_pkg::CNT_W-1:0] UV_LAST = bfs_pkg::CNT_W'(UV_CYCLES - 1);
	localparam logic [bfs_pkg::CNT_W-1:0] SW_DONE = bfs_pkg::CNT_W'(SWOVER_CYCLES);
	localparam logic [bfs_pkg::CNT_W-1:0] SS_LAST = bfs_pkg::CNT_W'(SS_COUNT_CYCLES - 1);
	localparam logic [bfs_pkg::CNT_W-1:0] CNT_ONE = bfs_pkg::CNT_W'(1);

	// ----------------------------------------------------------------
	// input synchronizers
	// ----------------------------------------------------------------
	logic [bfs_pkg::CMP_W-1:0] sync1_q, sync2_q, sync3_q, flt_vec_q;
	logic [bfs_pkg::CMP_W-1:0] flt_vec_d;
	bfs_pkg::bfs_cmp_t flt_d, flt_q;
	logic sw_tick;

	// flags filtered per bit
	// a level counts only once stages two and three agree, so a single
	// metastable sample never reaches the counters
	for (genvar b = 0; b < bfs_pkg::CMP_W; b++) begin : g_sync
		always_comb begin
			flt_vec_d[b] = (sync2_q[b] == sync3_q[b]) ? sync3_q[b] : flt_vec_q[b];
		end
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				{sync1_q[b], sync2_q[b], sync3_q[b], flt_vec_q[b]} <= 4'h0;
			end else begin
				{sync1_q[b], sync2_q[b], sync3_q[b], flt_vec_q[b]} <=
					{i_cmp[b], sync1_q[b], sync2_q[b], flt_vec_d[b]};
			end
		end
	end

	assign flt_q = bfs_pkg::bfs_cmp_t'(flt_vec_q);
	assign flt_d = bfs_pkg::bfs_cmp_t'(flt_vec_d);

	// switching-cycle tick: filtered level about to rise; both low out of reset
	assign sw_tick = flt_d.sw_cycle & ~flt_q.sw_cycle;

	// ----------------------------------------------------------------
	// enable decode and bias regulator
	// ----------------------------------------------------------------
	logic sw_allow, ldo_ready;
	logic ldo_on_d, ldo_on_q;
	bfs_pkg::bfs_ilim_t ilim_d, ilim_q;
	logic swover_d, swover_q;
	logic [bfs_pkg::CNT_W-1:0] sw_cnt_d, sw_cnt_q;
	logic pg_good_q;

	always_comb begin
		// regulator off below 1 V; off once rails joined
		ldo_on_d = flt_q.ldo_en_above_1v & ~swover_q;
		// hold switching until the bias rail is at 90 %
		ldo_ready = ~ldo_on_q | flt_q.bias_fb_above_90 | swover_q;
		sw_allow = flt_q.enable_powersave_in & flt_q.bias_above_on & ldo_ready &
			(flt_q.ldo_en_above_lock | ~flt_q.ldo_en_above_1v);
		// current limit steps follow the rising bias rail
		ilim_d = !ldo_on_q ? bfs_pkg::ILIM_65MA : flt_q.bias_fb_above_90 ? bfs_pkg::ILIM_200MA :
			flt_q.bias_above_075 ? bfs_pkg::ILIM_115MA : bfs_pkg::ILIM_65MA;
		// count switching cycles after power good rises
		sw_cnt_d = sw_cnt_q;
		swover_d = swover_q;
		if (!pg_good_q) begin
			sw_cnt_d = '0;
			swover_d = 1'b0;
		end else if (sw_cnt_q != SW_DONE) begin
			if (sw_tick) begin
				sw_cnt_d = sw_cnt_q + CNT_ONE;
			end
		end else if (flt_q.bias_out_close) begin
			// rails within 300 mV: close the joining switch
			swover_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ldo_on_q <= 1'b0;
			ilim_q <= bfs_pkg::ILIM_65MA;
			swover_q <= 1'b0;
			sw_cnt_q <= '0;
		end else begin
			ldo_on_q <= ldo_on_d;
			ilim_q <= ilim_d;
			swover_q <= swover_d;
			sw_cnt_q <= sw_cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// sequencer and fault detectors
	// ----------------------------------------------------------------
	bfs_pkg::bfs_state_t state_d, state_q;
	logic [bfs_pkg::CNT_W-1:0] ov_cnt_d, ov_cnt_q, uv_cnt_d, uv_cnt_q, ss_cnt_d, ss_cnt_q;
	logic ov_armed, uv_armed, ov_trip, uv_trip, por_d, por_q;

	always_comb begin
		// over-voltage watched in every enabled operating state
		ov_armed = flt_q.enable_powersave_in & (state_q inside {bfs_pkg::ST_POR, bfs_pkg::ST_IDLE,
			bfs_pkg::ST_PREBIAS, bfs_pkg::ST_RUN});
		// under-voltage only after the ramp, where 450 mV is abnormal
		uv_armed = (state_q == bfs_pkg::ST_RUN) & flt_q.ss_done;
		ov_trip = ov_armed & flt_q.fb_over & (ov_cnt_q == OV_LAST);
		ov_cnt_d = (ov_armed & flt_q.fb_over & ~ov_trip) ? ov_cnt_q + CNT_ONE : '0;
		// eight consecutive clocks below 450 mV
		uv_trip = uv_armed & flt_q.fb_under & (uv_cnt_q == UV_LAST);
		uv_cnt_d = (uv_armed & flt_q.fb_under & ~uv_trip) ? uv_cnt_q + CNT_ONE : '0;
		ss_cnt_d = '0;
		por_d = 1'b0;
		state_d = state_q;
		unique case (state_q)
			bfs_pkg::ST_LOCKOUT: begin
				// rising past 3 V issues the clear pulse
				if (flt_q.bias_above_on) begin
					por_d = 1'b1;
					state_d = bfs_pkg::ST_POR;
				end
			end
			bfs_pkg::ST_POR: begin
				ss_cnt_d = ss_cnt_q + CNT_ONE;
				if (ss_cnt_q == SS_LAST) begin
					state_d = bfs_pkg::ST_IDLE;
				end
			end
			bfs_pkg::ST_IDLE: begin
				if (sw_allow) begin
					state_d = bfs_pkg::ST_PREBIAS;
				end
			end
			bfs_pkg::ST_PREBIAS: begin
				// hold off until the ramp meets the existing output
				if (!sw_allow) begin
					state_d = bfs_pkg::ST_IDLE;
				end else if (flt_q.ss_meets_fb) begin
					state_d = bfs_pkg::ST_RUN;
				end
			end
			bfs_pkg::ST_RUN: begin
				if (!sw_allow) begin
					state_d = bfs_pkg::ST_IDLE;
				end
			end
			bfs_pkg::ST_OV, bfs_pkg::ST_UV: begin
				// fault held until enable goes low
				if (!flt_q.enable_powersave_in) begin
					state_d = bfs_pkg::ST_IDLE;
				end
			end
		endcase
		// faults override ordinary sequencing
		if (ov_trip) begin
			state_d = bfs_pkg::ST_OV;
		end else if (uv_trip) begin
			state_d = bfs_pkg::ST_UV;
		end
		// bias collapse below 2.4 V wins over everything
		if (!flt_q.bias_above_off) begin
			state_d = bfs_pkg::ST_LOCKOUT;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q <= bfs_pkg::ST_LOCKOUT;
			ov_cnt_q <= '0;
			uv_cnt_q <= '0;
			ss_cnt_q <= '0;
			por_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ov_cnt_q <= ov_cnt_d;
			uv_cnt_q <= uv_cnt_d;
			ss_cnt_q <= ss_cnt_d;
			por_q <= por_d;
		end
	end

	// ----------------------------------------------------------------
	// gate drive and power good
	// ----------------------------------------------------------------
	bfs_pkg::bfs_drive_t drive_d, drive_q;
	logic hyst_d, hyst_q, pg_good_d;
	logic pg_oe_d, pg_oe_q, ov_fault_d, ov_fault_q, uv_fault_d, uv_fault_q;

	always_comb begin
		drive_d = bfs_pkg::DRIVE_OFF;
		unique case (state_q)
			bfs_pkg::ST_RUN: begin
				drive_d.high_side = flt_q.on_time_req;
				// during the ramp never sink from a pre-biased output
				drive_d.low_side = ~flt_q.on_time_req & ~(~flt_q.ss_done & flt_q.il_negative);
			end
			bfs_pkg::ST_OV: begin
				// low side latched on to clamp the output
				drive_d.low_side = 1'b1;
			end
			// both drives low, power stage tristated
			default: drive_d = bfs_pkg::DRIVE_OFF;
		endcase
		// set beats clear so a recovery is never missed
		hyst_d = flt_q.fb_pg_ok | (hyst_q & ~flt_q.fb_pg_low);
		// over-voltage or disabled forces the pad low
		pg_good_d = (state_q == bfs_pkg::ST_RUN) & flt_q.ss_done & hyst_d &
			~flt_q.fb_over & flt_q.enable_powersave_in;
		// pad enable and fault flags registered so no output is decoded
		pg_oe_d = ~pg_good_d;
		ov_fault_d = (state_d == bfs_pkg::ST_OV);
		uv_fault_d = (state_d == bfs_pkg::ST_UV);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			drive_q <= bfs_pkg::DRIVE_OFF;
			hyst_q <= 1'b0;
			pg_good_q <= 1'b0;
			pg_oe_q <= 1'b1;
			{ov_fault_q, uv_fault_q} <= 2'h0;
		end else begin
			drive_q <= drive_d;
			hyst_q <= hyst_d;
			pg_good_q <= pg_good_d;
			pg_oe_q <= pg_oe_d;
			{ov_fault_q, uv_fault_q} <= {ov_fault_d, uv_fault_d};
		end
	end

	// open-drain: only ever drives zero
	assign o_drive = drive_q;
	assign o_power_good = 1'b0;
	assign o_power_good_oe = pg_oe_q;
	assign o_ldo_on = ldo_on_q;
	assign o_ldo_ilim = ilim_q;
	assign o_switchover = swover_q;
	assign o_por_clear = por_q;
	assign o_ov_fault = ov_fault_q;
	assign o_uv_fault = uv_fault_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	prebias_hold_a: assert property ((state_q == bfs_pkg::ST_PREBIAS && !flt_q.ss_meets_fb)
		|=> state_q != bfs_pkg::ST_RUN) else $error("run entered before ramp met feedback");
	prebias_sink_a: assert property ((state_q == bfs_pkg::ST_RUN && !flt_q.ss_done &&
		flt_q.il_negative) |=> !o_drive.low_side) else $error("low side on with negative current");
	pg_hyst_a: assert property ((flt_q.fb_pg_low && !flt_q.fb_pg_ok) |=> o_power_good_oe)
		else $error("power good high below threshold");
	pg_over_a: assert property ((flt_q.fb_over || !flt_q.enable_powersave_in) |=> o_power_good_oe)
		else $error("power good high during over-voltage or disable");
	ov_filter_a: assert property ((state_q == bfs_pkg::ST_OV && $past(state_q) != bfs_pkg::ST_OV)
		|-> $past(ov_cnt_q) == OV_LAST) else $error("over-voltage acted before filter time");
	ov_latch_a: assert property ((state_q == bfs_pkg::ST_OV && $past(state_q) == bfs_pkg::ST_OV)
		|-> o_drive.low_side && !o_drive.high_side) else $error("over-voltage clamp not held");
	uv_off_a: assert property ((flt_q.fb_under && uv_armed)[*8] ##1 flt_q.bias_above_off
		|=> o_drive == bfs_pkg::DRIVE_OFF || UV_CYCLES != 8) else $error("drives not off after under-voltage");
	uv_stay_a: assert property ((state_q == bfs_pkg::ST_UV && flt_q.enable_powersave_in && flt_q.bias_above_off)
		|=> state_q == bfs_pkg::ST_UV) else $error("under-voltage fault released early");
	lockout_a: assert property ((state_q == bfs_pkg::ST_LOCKOUT && $past(state_q) == bfs_pkg::ST_LOCKOUT)
		|-> o_drive == bfs_pkg::DRIVE_OFF) else $error("drives active in lockout");
	por_a: assert property ((state_q == bfs_pkg::ST_LOCKOUT && flt_q.bias_above_on && flt_q.bias_above_off)
		|=> o_por_clear && state_q == bfs_pkg::ST_POR) else $error("no clear pulse on bias rise");
	ldo_off_a: assert property (!flt_q.ldo_en_above_1v |=> !o_ldo_on)
		else $error("bias regulator on with enable low");
	swover_wait_a: assert property ($rose(o_switchover) |-> $past(sw_cnt_q) == SW_DONE &&
		$past(flt_q.bias_out_close)) else $error("switch-over closed too early");

	run_c: cover property (state_q == bfs_pkg::ST_PREBIAS ##1 state_q == bfs_pkg::ST_RUN);
	ov_c: cover property (state_q == bfs_pkg::ST_OV ##1 state_q == bfs_pkg::ST_IDLE);
	swover_c: cover property ($rose(o_switchover));
	uv_c: cover property ($rose(o_uv_fault));

endmodule : bfs_sequencer

/* bfs_sequencer_bench.sv */
// bfs_sequencer_bench: directed scenarios for the fault and bias sequencer.
// assumes bfs_plant turns levels into flags; inputs move on falling edges.
module bfs_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// stimulus and observed outputs
	// ----
	localparam int SETTLE = 16;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [15:0] fb_mv = 16'd600;
	logic [15:0] bias_mv = 16'd0;
	logic [15:0] ldo_mv = 16'd200;
	logic sw_run = 1'b0;
	bfs_pkg::bfs_cmp_t flags = '0;
	bfs_pkg::bfs_cmp_t cmp;
	bfs_pkg::bfs_drive_t drive;
	bfs_pkg::bfs_ilim_t ilim;
	logic pg, pg_oe, ldo_on, sw_over, por, ov, uv;
	int n_errors = 0;
	int comparisons = 0;

	always #10 i_clk = ~i_clk;

	bfs_plant plant (.i_clk(i_clk), .i_fb_mv(fb_mv), .i_bias_mv(bias_mv), .i_ldo_mv(ldo_mv),
		.i_sw_run(sw_run), .i_flags(flags), .o_cmp(cmp));

	// short soft-start and filter counts keep the run brief
	bfs_sequencer #(.OV_FILTER_CYCLES(5), .SS_COUNT_CYCLES(4)) DUT (.i_clk(i_clk), .i_rst(i_rst),
		.i_cmp(cmp), .o_drive(drive), .o_power_good(pg), .o_power_good_oe(pg_oe),
		.o_ldo_on(ldo_on), .o_ldo_ilim(ilim), .o_switchover(sw_over), .o_por_clear(por),
		.o_ov_fault(ov), .o_uv_fault(uv));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask : cyc

	task automatic print_verdict;
		if (n_errors == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict

	// clear pulses seen at rising edges over a span
	task automatic count_por;
		int k;
		k = 0;
		repeat (SETTLE) begin
			@(posedge i_clk);
			#1;
			if (por === 1'b1) k++;
		end
		check("por pulses", 16'(k), 16'h1);
		cyc(SETTLE);
	endtask : count_por

	task automatic toggle_en;
		flags.enable_powersave_in = 1'b0;
		cyc(SETTLE);
		flags.enable_powersave_in = 1'b1;
		cyc(SETTLE);
	endtask : toggle_en

	// outputs while reset is held
	task automatic t_reset;
		cyc(20);
		check("drive", drive, 2'h0);
		check("pg oe", 2'(pg_oe), 2'h1);
		check("pg data", 2'(pg), 2'h0);
		check("ldo on", 2'(ldo_on), 2'h0);
		check("ilim", ilim, 2'h0);
		check("switchover", 2'(sw_over), 2'h0);
		i_rst = 1'b0;
	endtask : t_reset

	// bias between stop and start levels, then a clean rise
	task automatic t_power_up;
		flags.enable_powersave_in = 1'b1;
		flags.ss_meets_fb = 1'b1;
		flags.on_time_req = 1'b1;
		flags.bias_fb_above_90 = 1'b1;
		bias_mv = 16'd2800;
		cyc(SETTLE);
		check("drive low bias", drive, 2'h0);
		bias_mv = 16'd3300;
		count_por();
		check("drive after por", drive, 2'h2);
	endtask : t_power_up

	// start into an existing output with negative inductor current
	task automatic t_prebias;
		flags.enable_powersave_in = 1'b0;
		flags.ss_meets_fb = 1'b0;
		flags.on_time_req = 1'b0;
		flags.il_negative = 1'b1;
		cyc(SETTLE);
		flags.enable_powersave_in = 1'b1;
		cyc(SETTLE);
		check("prebias hold", drive, 2'h0);
		flags.ss_meets_fb = 1'b1;
		cyc(SETTLE);
		check("neg current", drive, 2'h0);
		flags.il_negative = 1'b0;
		cyc(SETTLE);
		check("low side on", drive, 2'h1);
	endtask : t_prebias

	// 545 mV lies inside the band, so the last state must hold
	task automatic t_power_good;
		logic [15:0] lv [4] = '{16'd545, 16'd530, 16'd545, 16'd600};
		logic [1:0] ex [4] = '{2'h0, 2'h1, 2'h1, 2'h0};
		flags.ss_done = 1'b1;
		cyc(SETTLE);
		check("pg good", 2'(pg_oe), 2'h0);
		for (int i = 0; i < 4; i++) begin
			fb_mv = lv[i];
			cyc(SETTLE);
			check("pg band", 2'(pg_oe), ex[i]);
		end
	endtask : t_power_good

	// every row of the enable table
	task automatic t_table;
		logic [15:0] lv [3] = '{16'd200, 16'd1500, 16'd3000};
		logic sw;
		flags.on_time_req = 1'b1;
		for (int i = 0; i < 6; i++) begin
			flags.enable_powersave_in = i[0];
			ldo_mv = lv[i / 2];
			cyc(SETTLE);
			sw = i[0] && (lv[i / 2] < 16'd400 || lv[i / 2] > 16'd2600);
			check("switcher", 2'(drive.high_side), 2'(sw));
			check("ldo", 2'(ldo_on), 2'(lv[i / 2] > 16'd1000));
			check("pg oe", 2'(pg_oe), 2'(!sw));
		end
	endtask : t_table

	// regulator start steps, then the timed rail join
	task automatic t_ldo;
		flags.bias_fb_above_90 = 1'b0;
		flags.bias_above_075 = 1'b0;
		cyc(SETTLE);
		check("ilim low", ilim, 2'h0);
		check("hold for bias", drive, 2'h0);
		flags.bias_above_075 = 1'b1;
		cyc(SETTLE);
		check("ilim mid", ilim, 2'h1);
		flags.bias_fb_above_90 = 1'b1;
		flags.bias_out_close = 1'b1;
		cyc(SETTLE);
		check("ilim high", ilim, 2'h2);
		sw_run = 1'b1;
		cyc(254);
		check("swover early", 2'(sw_over), 2'h0);
		cyc(8);
		check("swover", 2'(sw_over), 2'h1);
		check("ldo off", 2'(ldo_on), 2'h0);
		flags.bias_out_close = 1'b0;
		toggle_en();
		cyc(300);
		check("swover apart", 2'(sw_over), 2'h0);
		sw_run = 1'b0;
	endtask : t_ldo

	// short excursion first, then a held one from pre-bias
	task automatic t_ov;
		flags.enable_powersave_in = 1'b0;
		flags.ss_meets_fb = 1'b0;
		cyc(SETTLE);
		flags.enable_powersave_in = 1'b1;
		fb_mv = 16'd800;
		cyc(3);
		fb_mv = 16'd600;
		cyc(SETTLE);
		check("ov short", 2'(ov), 2'h0);
		fb_mv = 16'd800;
		cyc(SETTLE);
		check("ov latch", 2'(ov), 2'h1);
		check("ov drive", drive, 2'h1);
		check("ov pg", 2'(pg_oe), 2'h1);
		fb_mv = 16'd600;
		flags.ss_meets_fb = 1'b1;
		cyc(SETTLE);
		check("ov hold", drive, 2'h1);
		toggle_en();
		check("ov cleared", drive, 2'h2);
	endtask : t_ov

	task automatic t_uv;
		fb_mv = 16'd400;
		cyc(5);
		fb_mv = 16'd600;
		cyc(SETTLE);
		check("uv short", 2'(uv), 2'h0);
		fb_mv = 16'd400;
		cyc(SETTLE);
		check("uv latch", 2'(uv), 2'h1);
		check("uv drive", drive, 2'h0);
		fb_mv = 16'd600;
		cyc(SETTLE);
		check("uv hold", drive, 2'h0);
		toggle_en();
		check("uv cleared", drive, 2'h2);
	endtask : t_uv

	task automatic t_bias;
		bias_mv = 16'd2800;
		cyc(SETTLE);
		check("bias low", drive, 2'h0);
		bias_mv = 16'd2000;
		cyc(SETTLE);
		check("bias lost", drive, 2'h0);
		bias_mv = 16'd3300;
		count_por();
		check("restart", drive, 2'h2);
	endtask : t_bias

	// reset in mid-run, then a full restart from lockout
	task automatic t_rst_mid;
		i_rst = 1'b1;
		cyc(2);
		check("rst drive", drive, 2'h0);
		check("rst ldo", 2'(ldo_on), 2'h0);
		check("rst pg oe", 2'(pg_oe), 2'h1);
		check("rst ov", 2'(ov), 2'h0);
		i_rst = 1'b0;
		count_por();
		check("rst restart", drive, 2'h2);
		check("rst ilim", ilim, 2'h2);
	endtask : t_rst_mid

	initial begin
		t_reset();
		t_power_up();
		t_prebias();
		t_power_good();
		t_table();
		t_ldo();
		t_ov();
		t_uv();
		t_bias();
		t_rst_mid();
		print_verdict();
	end

	// the scenarios need about 1230 clocks
	initial begin
		cyc(20000);
		n_errors++;
		print_verdict();
	end
endmodule : bfs_sequencer_bench
